// File: shared/lrro_defines.vh
// constants for the literal-return and rotate instruction executor
// assumes a 12-bit instruction word and 8-bit data path
// Functional notes
// - return-with-literal loads literal into accumulator
// - return-with-literal pops stack top into pc
// - return-with-literal takes two instruction cycles
// - left rotate through carry, carry only
// - right rotate through carry, carry only
// - left rotate: d=0 to accumulator, d=1 to file
// - right rotate: d=0 to accumulator, d=1 to file
`ifndef LRRO_DEFINES_VH
`define LRRO_DEFINES_VH
`define LRRO_OP_CFG_LOAD   12'h002
`define LRRO_RET_HI        4'h8
`define LRRO_ROT_HI        6'h0d
`define LRRO_ROT_LEFT_HI   6'h0d
`define LRRO_ROT_RIGHT_HI  6'h0c
`define LRRO_DIR_BIT       6
`define LRRO_DEST_BIT      5
`define LRRO_ADDR_MSB      4
`define LRRO_CFG_RESET     8'hff
`define LRRO_ACC_RESET     8'h00
`define LRRO_ST_EXEC       1'b0
`define LRRO_ST_FLUSH      1'b1
`define LRRO_RET_MSB       11
`define LRRO_RET_LSB       8
`define LRRO_ROT_MSB       11
`define LRRO_ROT_LSB       7
`define LRRO_ROT_CODE      5'h06
`define LRRO_LIT_MSB       7
`define LRRO_DATA_MSB      7
`define LRRO_CARRY_RESET   1'b0
`define LRRO_WADDR_RESET   5'h00
`define LRRO_WDATA_RESET   8'h00
`endif

// File: src/lrro_exec.v
// executes the config-load, return-with-literal and the two rotate instructions
// assumes the fetch stage presents instr with instr_valid each instruction cycle,
// the register file returns file_rdata combinationally for file_addr, and the
// stack offers stack_top; writes and pops are one-cycle pulses
`default_nettype none
`include "lrro_defines.vh"
module lrro_exec #(
  parameter PC_W = 10
) (
  input  wire            clk,
  input  wire            rst_n,
  input  wire            instr_valid,
  input  wire [11:0]     instr,
  input  wire [7:0]      file_rdata,
  input  wire [PC_W-1:0] stack_top,
  output wire [4:0]      file_addr,
  output reg  [7:0]      acc_q,
  output reg  [7:0]      cfg_q,
  output reg             carry_q,
  output reg             file_we_q,
  output reg  [4:0]      file_waddr_q,
  output reg  [7:0]      file_wdata_q,
  output reg             stack_pop_q,
  output reg             pc_load_q,
  output reg  [PC_W-1:0] pc_value_q,
  output reg             busy_q
);
  reg rst_s1_q;
  reg rst_s2_q;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end

  // instruction classes after decode
  localparam CLS_NONE = 2'b00;
  localparam CLS_CFG  = 2'b01;
  localparam CLS_RET  = 2'b10;
  localparam CLS_ROT  = 2'b11;

  // sequencer states
  localparam ST_EXEC  = `LRRO_ST_EXEC;
  localparam ST_FLUSH = `LRRO_ST_FLUSH;

  // address goes straight to the file; read data is combinational
  // so a rotate finishes in the cycle it is offered
  assign file_addr = instr[`LRRO_ADDR_MSB:0];

  reg            state_q;
  reg            state_d;
  reg  [7:0]     acc_d;
  reg  [7:0]     cfg_d;
  reg            carry_d;
  reg            file_we_d;
  reg  [4:0]     file_waddr_d;
  reg  [7:0]     file_wdata_d;
  reg            stack_pop_d;
  reg            pc_load_d;
  reg [PC_W-1:0] pc_value_d;
  reg            busy_d;
  reg  [1:0]     op_cls;
  reg  [7:0]     rot_res;
  reg            rot_c;

  // instruction fields
  wire           exec     = instr_valid && (state_q == ST_EXEC);
  wire [3:0]     ret_hi   = instr[`LRRO_RET_MSB:`LRRO_RET_LSB];
  wire [4:0]     rot_hi   = instr[`LRRO_ROT_MSB:`LRRO_ROT_LSB];
  wire [7:0]     literal  = instr[`LRRO_LIT_MSB:0];
  wire [4:0]     f_addr   = instr[`LRRO_ADDR_MSB:0];
  wire           rot_left = instr[`LRRO_DIR_BIT];
  wire           to_file  = instr[`LRRO_DEST_BIT];

  // nothing is taken in the flush cycle, so exec gates every class
  always @* begin
    op_cls = CLS_NONE;
    if (exec) begin
      if (instr == `LRRO_OP_CFG_LOAD)
        op_cls = CLS_CFG;
      else if (ret_hi == `LRRO_RET_HI)
        op_cls = CLS_RET;
      else if (rot_hi == `LRRO_ROT_CODE)
        op_cls = CLS_ROT;
    end
  end

  // rotate datapath: the carry is the ninth bit of the ring
  always @* begin
    if (rot_left) begin
      rot_res = {file_rdata[`LRRO_DATA_MSB-1:0], carry_q};
      rot_c   = file_rdata[`LRRO_DATA_MSB];
    end else begin
      rot_res = {carry_q, file_rdata[`LRRO_DATA_MSB:1]};
      rot_c   = file_rdata[0];
    end
  end

  // next-state logic; pulses fall back to zero every cycle
  always @* begin
    state_d      = state_q;
    acc_d        = acc_q;
    cfg_d        = cfg_q;
    carry_d      = carry_q;
    file_we_d    = 1'b0;
    file_waddr_d = file_waddr_q;
    file_wdata_d = file_wdata_q;
    stack_pop_d  = 1'b0;
    pc_load_d    = 1'b0;
    pc_value_d   = pc_value_q;
    busy_d       = 1'b0;
    case (state_q)
      ST_EXEC: begin
        case (op_cls)
          CLS_CFG: begin
            // status flags are left alone here
            cfg_d = acc_q;
          end
          CLS_RET: begin
            acc_d       = literal;
            stack_pop_d = 1'b1;
            pc_load_d   = 1'b1;
            pc_value_d  = stack_top;
            // prefetched word is stale once pc changes
            state_d     = ST_FLUSH;
            busy_d      = 1'b1;
          end
          CLS_ROT: begin
            carry_d = rot_c;
            if (to_file) begin
              file_we_d    = 1'b1;
              file_waddr_d = f_addr;
              file_wdata_d = rot_res;
            end else begin
              acc_d = rot_res;
            end
          end
          default: begin
            // other opcodes belong elsewhere; nothing changes
            state_d = ST_EXEC;
          end
        endcase
      end
      ST_FLUSH: begin
        // second cycle: whatever was fetched is dropped
        state_d = ST_EXEC;
      end
      default: begin
        state_d = ST_EXEC;
      end
    endcase
  end

  // state and output registers; every output except file_addr leaves from here
  always @(posedge clk or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      state_q      <= ST_EXEC;
      acc_q        <= `LRRO_ACC_RESET;
      cfg_q        <= `LRRO_CFG_RESET;
      carry_q      <= `LRRO_CARRY_RESET;
      file_we_q    <= 1'b0;
      file_waddr_q <= `LRRO_WADDR_RESET;
      file_wdata_q <= `LRRO_WDATA_RESET;
      stack_pop_q  <= 1'b0;
      pc_load_q    <= 1'b0;
      pc_value_q   <= {PC_W{1'b0}};
      busy_q       <= 1'b0;
    end else begin
      state_q      <= state_d;
      acc_q        <= acc_d;
      cfg_q        <= cfg_d;
      carry_q      <= carry_d;
      file_we_q    <= file_we_d;
      file_waddr_q <= file_waddr_d;
      file_wdata_q <= file_wdata_d;
      stack_pop_q  <= stack_pop_d;
      pc_load_q    <= pc_load_d;
      pc_value_q   <= pc_value_d;
      busy_q       <= busy_d;
    end
  end

  // limitation: file_addr is the only output not from a flop, since the
  // register file must answer within the same instruction cycle
endmodule // lrro_exec
`default_nettype wire

// File: tb/lrro_exec_monitor.sv
// port checker for lrro_exec, bound to every instance
`default_nettype none
module lrro_mon (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        instr_valid,
  input wire logic [11:0] instr,
  input wire logic [7:0]  file_rdata,
  input wire logic [9:0]  stack_top,
  input wire logic [4:0]  file_addr,
  input wire logic [7:0]  acc_q,
  input wire logic [7:0]  cfg_q,
  input wire logic        carry_q,
  input wire logic        file_we_q,
  input wire logic [4:0]  file_waddr_q,
  input wire logic [7:0]  file_wdata_q,
  input wire logic        stack_pop_q,
  input wire logic        pc_load_q,
  input wire logic [9:0]  pc_value_q,
  input wire logic        busy_q
);
  timeunit 1ns;
  timeprecision 1ps;
  // nothing is taken in the flush cycle, so t masks every opcode trigger; a_flush_idle keys on busy_q itself
  wire t = instr_valid & !busy_q, r = t & instr[11:8] == 4'h8;
  wire [6:0] o = t ? instr[11:5] : 7'h0;
  wire [8:0] f = {file_rdata, carry_q}, b = {carry_q, file_rdata};
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_lit_acc: assert property (r |=> acc_q == $past(instr[7:0])) else $error("lit");
  a_ret_pc: assert property (r |=> pc_value_q == $past(stack_top)) else $error("pc");
  a_ret_gap: assert property (r |=> busy_q ##1 !busy_q) else $error("gap");
  a_rl_acc: assert property (o == 7'h1a |=> {carry_q, acc_q} == $past(f))
    else $error("rla");
  a_rl_file: assert property (o == 7'h1b |=>
    file_we_q && {carry_q, file_wdata_q} == $past(f)) else $error("rlf");
  a_rr_acc: assert property (o == 7'h18 |=> {acc_q, carry_q} == $past(b))
    else $error("rra");
  a_rr_file: assert property (o == 7'h19 |=>
    file_we_q && {file_wdata_q, carry_q} == $past(b)) else $error("rrf");
  a_cfg_copy: assert property (t & instr == 12'h002 |=> cfg_q == $past(acc_q))
    else $error("cfg");
  a_cfg_flags: assert property (t & instr == 12'h002 |=> $stable(carry_q))
    else $error("cfg carry");
  a_ret_pulse: assert property (r |=> stack_pop_q && pc_load_q) else $error("pop");
  a_flush_idle: assert property (busy_q |=> !file_we_q && !stack_pop_q && !pc_load_q
    && $stable(acc_q) && $stable(cfg_q) && $stable(carry_q)) else $error("flush");
  a_rot_waddr: assert property ((o == 7'h1b || o == 7'h19) |=>
    file_waddr_q == $past(instr[4:0])) else $error("waddr");
  a_read_addr: assert property (file_addr == instr[4:0]) else $error("raddr");
  c_ret: cover property (r ##1 busy_q);
  c_rot: cover property (o[6:2] == 5'h06);
  c_cfg: cover property (t & instr == 12'h002);
endmodule // lrro_mon
bind lrro_exec lrro_mon u_mon (.*);
`default_nettype wire

// File: tb/testbench.sv
// self-checking bench for lrro_exec; drives every input itself
`default_nettype none
module testbench;
  timeunit 1ns; timeprecision 1ps;
  logic clk = 1'b0, rst_n = 1'b0, instr_valid = 1'b0, carry_q, c = 1'b0;
  logic file_we_q, stack_pop_q, pc_load_q, busy_q;
  logic [4:0] file_addr, file_waddr_q;
  logic [11:0] instr = 12'h0;
  logic [7:0] file_rdata = 8'h0, acc_q, cfg_q, file_wdata_q, d;
  logic [9:0] stack_top = 10'h0, pc_value_q;
  int failures = 0, tests_run = 0;
  lrro_exec dut (
    .clk          (clk),
    .rst_n        (rst_n),
    .instr_valid  (instr_valid),
    .instr        (instr),
    .file_rdata   (file_rdata),
    .stack_top    (stack_top),
    .file_addr    (file_addr),
    .acc_q        (acc_q),
    .cfg_q        (cfg_q),
    .carry_q      (carry_q),
    .file_we_q    (file_we_q),
    .file_waddr_q (file_waddr_q),
    .file_wdata_q (file_wdata_q),
    .stack_pop_q  (stack_pop_q),
    .pc_load_q    (pc_load_q),
    .pc_value_q   (pc_value_q),
    .busy_q       (busy_q)
  );
  initial forever #4 clk = ~clk;
  task automatic chk(string n, logic [17:0] e, g);
    tests_run++;
    if (g !== e) begin failures++; $display("BAD %s exp %h got %h", n, e, g); end
  endtask
  task automatic op(logic [11:0] i, logic [7:0] v = 8'h0);
    @(posedge clk) {instr_valid, instr, file_rdata} <= {1'b1, i, v};
    @(posedge clk) instr_valid <= 1'b0;
    #1;
  endtask
  task automatic t_cfg;
    // right rotate of 0x01 into the accumulator leaves the carry set
    op(12'h300, 8'h01); op(12'h85a); op(12'h002);
    c = 1'b1;
    chk("cfg", 18'h5a, cfg_q);
    chk("cfg_carry", 18'h1, carry_q);
  endtask
  task automatic t_ret;
    @(posedge clk) {instr_valid, instr, stack_top} <= {1'b1, 12'h8ab, 10'h2a5};
    // second word lands in the flush cycle and must be dropped
    @(posedge clk) instr <= 12'h8cd;
    #1 chk("ret_go", 18'h7, {stack_pop_q, pc_load_q, busy_q});
    @(posedge clk) instr_valid <= 1'b0;
    #1 chk("ret", {10'h2a5, 8'hab}, {pc_value_q, acc_q});
    chk("ret_end", 18'h0, {stack_pop_q, pc_load_q, busy_q});
  endtask
  task automatic t_rot;
    for (int i = 0; i < 4; i++) begin
      d = 8'he6 ^ 8'(i * 77);
      op({7'h18 + 7'(i), 5'(i + 5)}, d);
      {c, d} = i[1] ? {d, c} : {d[0], c, d[7:1]};
      chk("rot", {c, d}, {carry_q, i[0] ? file_wdata_q : acc_q});
      chk("rot_we", i[0], file_we_q);
      chk("rot_raddr", 5'(i + 5), file_addr);
      if (i[0]) chk("rot_waddr", 5'(i + 5), file_waddr_q);
    end
  endtask
  task end_sim;
    if (failures == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk("rst", 18'h0ff, {carry_q, acc_q, cfg_q});
    t_cfg; t_ret; t_rot; end_sim;
  end
endmodule // testbench
`default_nettype wire
